// *** core/tde_params.svh ***
// constants for the transmit data encoder: offsets, fields, resets, sizes
`ifndef TDE_PARAMS_SVH
`define TDE_PARAMS_SVH

// register offsets on the control port
`define TDE_ADDR_TX_CONFIG_ONE 6'h05
`define TDE_ADDR_SCRAMBLER_SEED 6'h08
`define TDE_ADDR_PLAIN_PREFIX 6'h27

// reset values
`define TDE_TX_CONFIG_ONE_RST 8'h25
`define TDE_SCRAMBLER_SEED_RST 8'hab
`define TDE_PLAIN_PREFIX_RST 8'h00

// field positions in tx_config_one
`define TDE_INVERT_BIT 3
`define TDE_CODE_MSB 2
`define TDE_CODE_LSB 0

// payload buffer depth
`define TDE_FIFO_DEPTH 8

`endif

// *** core/tde_pkg.sv ***
// types shared by the transmit data encoder files
package tde_pkg;

  // code_select field values, in field order 000..111
  typedef enum logic [2:0] {
    TDE_MANCH,
    TDE_DIFF_MANCH,
    TDE_BIPHASE_SPACE,
    TDE_BIPHASE_MARK,
    TDE_MILLER,
    TDE_NRZ,
    TDE_PRBS,
    TDE_ZERO
  } tde_code_e;

  // chip sequencer states
  typedef enum logic [1:0] {
    TDE_IDLE,
    TDE_FIRST,
    TDE_SECOND
  } tde_state_e;

  // register access from the control port front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tde_reg_req_s;

  // flags carried by the transmit command
  typedef struct packed {
    logic data_sync;
    logic code_select_alt_en;
  } tde_tx_cmd_s;

  // encoded chip output
  typedef struct packed {
    logic strobe;
    logic level;
  } tde_chip_s;

endpackage : tde_pkg

// *** core/tde_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module tde_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push;
  wire pop;

  // honest full and empty from the fill count
  assign in_ready = (count_q < (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // pointers and count, wrapping at DEPTH
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : tde_fifo

`default_nettype wire

// *** core/tde_encoder.sv ***
// transmit line encoder and pseudo-random data scrambler
`timescale 1ns/1ps
`default_nettype none
`include "tde_params.svh"

module tde_encoder #(
  parameter int FIFO_DEPTH = `TDE_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire tde_pkg::tde_reg_req_s reg_req,
  output logic [7:0] reg_rdata_q,
  input wire logic tx_start,
  input wire tde_pkg::tde_tx_cmd_s tx_cmd,
  input wire logic tx_stop,
  input wire logic chip_tick,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic pay_bit,
  output tde_pkg::tde_chip_s chip_q,
  output logic tx_active_q,
  output logic underrun_q
);
  import tde_pkg::*;

  // registers written by the host
  logic [7:0] cfg_q;
  logic [7:0] seed_q;
  logic [7:0] prefix_q;
  // sequencer state
  tde_state_e state_q;
  logic enc_on_q;
  tde_code_e code_q;
  logic inv_q;
  logic [7:0] cnt_q;
  logic [8:0] prbs_q;
  logic lvl_q;
  logic prev_bit_q;
  logic second_q;
  logic sec_plain_q;

  wire fifo_valid;
  wire fifo_bit;
  wire pop;
  wire plain;
  wire two_chip;
  wire scramble;
  wire prbs_fb;
  wire inv_now;
  wire data_bit;
  logic c0;
  logic c1;

  // register writes; reads of tx_config_one show the stored fields
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= `TDE_TX_CONFIG_ONE_RST;
      seed_q <= `TDE_SCRAMBLER_SEED_RST;
      prefix_q <= `TDE_PLAIN_PREFIX_RST;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `TDE_ADDR_TX_CONFIG_ONE)
        cfg_q <= reg_req.wdata;
      if (reg_req.addr == `TDE_ADDR_SCRAMBLER_SEED)
        seed_q <= reg_req.wdata;
      if (reg_req.addr == `TDE_ADDR_PLAIN_PREFIX)
        prefix_q <= reg_req.wdata;
    end
  end

  // read data: only tx_config_one is readable, others read zero
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_q <= 8'h00;
    else if (reg_req.rd)
      reg_rdata_q <= (reg_req.addr == `TDE_ADDR_TX_CONFIG_ONE) ? cfg_q : 8'h00;
  end

  // payload buffer; bits leave only on a chip tick that starts a bit
  tde_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .flush(tx_start),
    .in_valid(pay_valid),
    .in_ready(pay_ready),
    .in_data(pay_bit),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_bit)
  );

  // bit timing and mode decode
  assign pop = (state_q == TDE_FIRST) && chip_tick && fifo_valid;
  assign plain = !enc_on_q || (cnt_q < prefix_q);
  assign two_chip = enc_on_q && (code_q != TDE_NRZ);
  assign scramble = enc_on_q && (code_q == TDE_PRBS) && !plain;
  assign prbs_fb = prbs_q[8] ^ prbs_q[4];
  assign data_bit = scramble ? (fifo_bit ^ prbs_q[8]) : fifo_bit;
  assign inv_now = enc_on_q && inv_q;

  // chip pair for the bit now taken, before inversion
  always_comb
  begin
    c0 = data_bit;
    c1 = data_bit;
    if (!plain)
    begin
      unique case (code_q)
        TDE_MANCH:
        begin
          c0 = data_bit;
          c1 = !data_bit;
        end
        TDE_DIFF_MANCH:
        begin
          c0 = data_bit ? lvl_q : !lvl_q;
          c1 = !c0;
        end
        TDE_BIPHASE_SPACE:
        begin
          c0 = !lvl_q;
          c1 = data_bit ? c0 : !c0;
        end
        TDE_BIPHASE_MARK:
        begin
          c0 = !lvl_q;
          c1 = data_bit ? !c0 : c0;
        end
        TDE_MILLER:
        begin
          c0 = (!data_bit && !prev_bit_q) ? !lvl_q : lvl_q;
          c1 = data_bit ? !c0 : c0;
        end
        TDE_NRZ, TDE_PRBS:
        begin
          c0 = data_bit;
          c1 = data_bit;
        end
        TDE_ZERO:
        begin
          c0 = 1'b0;
          c1 = 1'b0;
        end
      endcase
    end
  end

  // sequencer: start, bit taking, chip emission, stop
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= TDE_IDLE;
      enc_on_q <= 1'b0;
      code_q <= TDE_NRZ;
      inv_q <= 1'b0;
      cnt_q <= 8'h00;
      prbs_q <= 9'h000;
      lvl_q <= 1'b0;
      prev_bit_q <= 1'b1;
      second_q <= 1'b0;
      sec_plain_q <= 1'b0;
      chip_q <= '0;
      tx_active_q <= 1'b0;
      underrun_q <= 1'b0;
    end
    else
    begin
      chip_q.strobe <= 1'b0;
      underrun_q <= 1'b0;
      if (tx_start)
      begin
        state_q <= TDE_FIRST;
        tx_active_q <= 1'b1;
        enc_on_q <= tx_cmd.code_select_alt_en && tx_cmd.data_sync;
        code_q <= tde_code_e'(cfg_q[`TDE_CODE_MSB:`TDE_CODE_LSB]);
        inv_q <= cfg_q[`TDE_INVERT_BIT];
        cnt_q <= 8'h00;
        prbs_q <= {1'b0, seed_q};
        lvl_q <= 1'b0;
        prev_bit_q <= 1'b1;
      end
      else if (tx_stop)
      begin
        state_q <= TDE_IDLE;
        tx_active_q <= 1'b0;
      end
      else if (pop)
      begin
        chip_q.strobe <= 1'b1;
        chip_q.level <= c0 ^ inv_now;
        if (cnt_q != 8'hff)
          cnt_q <= cnt_q + 8'h01;
        if (scramble)
          prbs_q <= {prbs_q[7:0], prbs_fb};
        prev_bit_q <= data_bit;
        if (two_chip)
        begin
          state_q <= TDE_SECOND;
          second_q <= c1;
          sec_plain_q <= plain;
          lvl_q <= c0;
        end
        else
          lvl_q <= c0;
      end
      else if ((state_q == TDE_SECOND) && chip_tick)
      begin
        chip_q.strobe <= 1'b1;
        chip_q.level <= second_q ^ inv_now;
        lvl_q <= second_q;
        state_q <= TDE_FIRST;
      end
      else if ((state_q == TDE_FIRST) && chip_tick)
        underrun_q <= 1'b1;
    end
  end

  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic seen_q;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      seen_q <= 1'b0;
    else
      seen_q <= 1'b1;
  end

  sequence two_chip_take_s;
    pop && two_chip;
  endsequence

  sequence second_chip_s;
    (state_q == TDE_SECOND) && chip_tick && !tx_start && !tx_stop;
  endsequence

  seed_reset_value_a: assert property (!seen_q |-> seed_q == 8'hab)
    else $error("seed register not 0xab after reset");

  prbs_reload_a: assert property (
    tx_start |=> prbs_q == {1'b0, $past(seed_q)})
    else $error("generator not reloaded from seed at start");

  nrz_one_chip_a: assert property (
    pop && enc_on_q && code_q == TDE_NRZ && !tx_start && !tx_stop
    |=> chip_q.strobe && state_q == TDE_FIRST
        && chip_q.level == ($past(fifo_bit) ^ $past(inv_q)))
    else $error("nrz bit did not give one chip");

  two_chip_pair_a: assert property (
    two_chip_take_s and (!tx_start && !tx_stop)
    |=> state_q == TDE_SECOND && chip_q.strobe)
    else $error("two-chip code did not wait for second chip");

  manch_opposite_a: assert property (
    second_chip_s and (code_q == TDE_MANCH && !sec_plain_q)
    |=> chip_q.strobe
        && chip_q.level != $past(chip_q.level))
    else $error("manchester chips not opposite");

  code_select_alt_off_plain_a: assert property (
    pop && !enc_on_q && !tx_start && !tx_stop
    |=> chip_q.level == $past(fifo_bit) && state_q == TDE_FIRST)
    else $error("disabled encoder altered payload");

  zero_code_a: assert property (
    pop && enc_on_q && code_q == TDE_ZERO && !plain && !tx_start && !tx_stop
    |=> chip_q.level == $past(inv_q) ##0 state_q == TDE_SECOND)
    else $error("unused code did not force zero");

  prefix_plain_a: assert property (
    pop && enc_on_q && cnt_q < prefix_q && !tx_start && !tx_stop
    |=> chip_q.level == ($past(fifo_bit) ^ $past(inv_q)))
    else $error("prefix bit not sent plain");

  scramble_xor_a: assert property (
    pop && scramble && !tx_start && !tx_stop
    |=> chip_q.level == ($past(fifo_bit) ^ $past(prbs_q[8]) ^ $past(inv_q))
        && prbs_q == {$past(prbs_q[7:0]), $past(prbs_fb)})
    else $error("scrambled bit or generator step wrong");

  biphase_edge_a: assert property (
    pop && !plain && !tx_start && !tx_stop
    && (code_q == TDE_BIPHASE_SPACE || code_q == TDE_BIPHASE_MARK)
    |=> chip_q.level != ($past(lvl_q) ^ $past(inv_q)))
    else $error("bi-phase missed its bit-boundary edge");

endmodule : tde_encoder

`default_nettype wire

// *** sim/tde_host_model.sv ***
// host model that streams a twelve bit payload word, msb first
`timescale 1ns/1ps
`default_nettype none

module tde_host_model (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic send,
  input wire logic [11:0] word,
  input wire logic pay_ready,
  output logic pay_valid,
  output logic pay_bit
);
  logic [3:0] left;
  logic [11:0] sh;

  // bits go out only after the bench has issued the command
  // a released data line shows the inverse of its last bit
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left <= 4'h0;
      sh <= 12'h000;
      pay_valid <= 1'b0;
      pay_bit <= 1'b0;
    end
    else if (send)
    begin
      sh <= word;
      left <= 4'hc;
      pay_valid <= 1'b1;
      pay_bit <= word[11];
    end
    else if (pay_valid && pay_ready)
    begin
      left <= left - 4'h1;
      sh <= {sh[10:0], 1'b0};
      pay_valid <= (left != 4'h1);
      pay_bit <= (left == 4'h1) ? ~pay_bit : sh[10];
    end
  end
endmodule : tde_host_model

`default_nettype wire

// *** sim/tx_data_encoder_scrambler_bench.sv ***
// self-checking bench for the transmit data encoder
`timescale 1ns/1ps
`default_nettype none

module tx_data_encoder_scrambler_bench;
  import tde_pkg::*;
  logic sys_clk, arst_n, tx_start, tx_stop, chip_tick, send;
  logic pay_valid, pay_ready, pay_bit, tx_active_q, underrun_q;
  logic [7:0] rdata, d;
  tde_reg_req_s req;
  tde_tx_cmd_s tx_cmd;
  tde_chip_s chip_q;
  int fail_count, compares, un, full, k;
  logic got[$];
  localparam logic [11:0] W = 12'hb38;

  tde_encoder tde_encoder_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_req(req), .reg_rdata_q(rdata), .tx_start(tx_start),
    .tx_cmd(tx_cmd), .tx_stop(tx_stop), .chip_tick(chip_tick),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_bit(pay_bit),
    .chip_q(chip_q), .tx_active_q(tx_active_q), .underrun_q(underrun_q));

  tde_host_model tde_host_model_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .send(send), .word(W), .pay_ready(pay_ready), .pay_valid(pay_valid),
    .pay_bit(pay_bit));

  // clock of 4 ns period
  always #2 sys_clk = ~sys_clk;

  // collect chips, underruns and buffer refusals
  always @(posedge sys_clk)
  begin
    if (chip_q.strobe === 1'b1) got.push_back(chip_q.level);
    if (underrun_q === 1'b1) un++;
    if (pay_ready === 1'b0) full++;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge sys_clk) req <= {1'b1, 1'b0, a, v};
    @(posedge sys_clk) req <= '0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge sys_clk) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) req <= '0;
    @(posedge sys_clk) v = rdata;
  endtask : rd

  task pulse_start(input logic [1:0] cmd);
    @(posedge sys_clk)
    begin
      tx_start <= 1'b1;
      tx_cmd <= cmd;
    end
    @(posedge sys_clk) tx_start <= 1'b0;
  endtask : pulse_start

  task tick;
    repeat (3) @(posedge sys_clk);
    chip_tick <= 1'b1;
    @(posedge sys_clk) chip_tick <= 1'b0;
  endtask : tick

  // reference encoding of W, then one transmission and a chip compare
  task automatic run_tx(input logic [2:0] code, input logic inv,
    input logic [7:0] pre, input logic [1:0] cmd, input logic [7:0] seed);
    logic [8:0] st;
    logic lv, pv, b, c1, c2, on;
    logic q[$];
    st = {1'b0, seed};
    lv = 1'b0;
    pv = 1'b1;
    on = &cmd;
    for (int i = 0; i < 12; i++)
    begin
      b = W[11 - i];
      if (!on || code == 3'h5) q.push_back(b ^ (on & inv));
      else
      begin
        c1 = b;
        c2 = b;
        if (i >= pre)
          case (code)
            3'h0:
              c2 = ~b;
            3'h1:
            begin
              c1 = b ? lv : ~lv;
              c2 = ~c1;
            end
            3'h2:
            begin
              c1 = ~lv;
              c2 = b ? c1 : ~c1;
            end
            3'h3:
            begin
              c1 = ~lv;
              c2 = b ? ~c1 : c1;
            end
            3'h4:
            begin
              c1 = (b | pv) ? lv : ~lv;
              c2 = b ? ~c1 : c1;
            end
            3'h6:
            begin
              c1 = b ^ st[8];
              c2 = c1;
              st = {st[7:0], st[8] ^ st[4]};
            end
            default:
            begin
              c1 = 1'b0;
              c2 = 1'b0;
            end
          endcase
        lv = c2;
        pv = b;
        q.push_back(c1 ^ inv);
        q.push_back(c2 ^ inv);
      end
    end
    wr(6'h05, {4'h0, inv, code});
    wr(6'h27, pre);
    got.delete();
    un = 0;
    pulse_start(cmd);
    send <= 1'b1;
    @(posedge sys_clk) send <= 1'b0;
    check(tx_active_q, 1'b1);
    foreach (q[j]) tick();
    repeat (3) @(posedge sys_clk);
    tx_stop <= 1'b1;
    @(posedge sys_clk) tx_stop <= 1'b0;
    @(posedge sys_clk) check(tx_active_q, 1'b0);
    check(got.size(), q.size());
    foreach (q[j]) check(got[j], q[j]);
    check(un, 0);
    $display("test code %0d inv %0d pre %0d done", code, inv, pre);
  endtask : run_tx

  // watchdog against a hang
  initial
  begin
    #40000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    sys_clk = 0;
    arst_n = 0;
    req = '0;
    tx_start = 0;
    tx_cmd = '0;
    tx_stop = 0;
    chip_tick = 0;
    send = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(6'h05, d);
    check(d, 8'h25);
    rd(6'h08, d);
    check(d, 8'h00);
    rd(6'h27, d);
    check(d, 8'h00);
    $display("test register reset done");
    run_tx(3'h6, 1'b0, 8'h00, 2'b11, 8'hab);
    for (k = 0; k < 8; k++)
      run_tx(k[2:0], 1'b0, 8'h00, 2'b11, 8'hab);
    run_tx(3'h0, 1'b1, 8'h00, 2'b11, 8'hab);
    run_tx(3'h5, 1'b1, 8'h00, 2'b11, 8'hab);
    run_tx(3'h0, 1'b1, 8'h00, 2'b10, 8'hab);
    run_tx(3'h0, 1'b0, 8'h00, 2'b00, 8'hab);
    run_tx(3'h0, 1'b0, 8'h03, 2'b11, 8'hab);
    run_tx(3'h6, 1'b0, 8'h03, 2'b11, 8'hab);
    wr(6'h08, 8'h5a);
    run_tx(3'h6, 1'b0, 8'h00, 2'b11, 8'h5a);
    run_tx(3'h6, 1'b0, 8'h00, 2'b11, 8'h5a);
    check(full > 0, 1);
    wr(6'h10, 8'h77);
    rd(6'h10, d);
    check(d, 8'h00);
    wr(6'h05, 8'h0b);
    rd(6'h05, d);
    check(d, 8'h0b);
    $display("test register access done");
    un = 0;
    pulse_start(2'b11);
    tick();
    repeat (3) @(posedge sys_clk);
    check(un, 1);
    $display("test underrun done");
    wrap_up();
  end
endmodule : tx_data_encoder_scrambler_bench

`default_nettype wire
